// *** logic/scan_port_defines.vh ***
`ifndef SCAN_PORT_DEFINES_VH
`define SCAN_PORT_DEFINES_VH

`define IR_LEN 4
`define OP_EXTEST 4'h0
`define OP_SAMPLE 4'h1
`define OP_IDCODE 4'h2
`define OP_USERCODE 4'h3
`define OP_CFG_DATA 4'h4
`define OP_CFG_START 4'h5
`define OP_ANALYZER 4'h6
`define OP_BYPASS 4'hF
`define IR_CAPTURE 4'h1

`define ID_VERSION 4'h1
`define ID_PART 16'h1234
`define ID_MAKER 11'h155
`define USERCODE_RST 32'hFFFFFFFF

`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SH_DR 4'h4
`define ST_EX1_DR 4'h5
`define ST_PA_DR 4'h6
`define ST_EX2_DR 4'h7
`define ST_UP_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'hA
`define ST_SH_IR 4'hB
`define ST_EX1_IR 4'hC
`define ST_PA_IR 4'hD
`define ST_EX2_IR 4'hE
`define ST_UP_IR 4'hF

`endif

// *** logic/scan_pin_sync.v ***
module scan_pin_sync #(
    parameter WIDTH = 3
) (
    input wire i_clk,
    input wire i_rstn,
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta;

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta <= {WIDTH{1'b0}};
            o_sync <= {WIDTH{1'b0}};
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule

// *** logic/scan_tap_fsm.v ***
`include "scan_port_defines.vh"

module scan_tap_fsm (
    input wire i_clk,
    input wire i_rstn,
    input wire i_tck_rise,
    input wire i_tms,
    input wire i_sync_reset,
    output reg [3:0] o_state
);
    reg [3:0] next_state;

    always @* begin
        case (o_state)
            `ST_RESET: next_state = i_tms ? `ST_RESET : `ST_IDLE;
            `ST_IDLE: next_state = i_tms ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_DR: next_state = i_tms ? `ST_SEL_IR : `ST_CAP_DR;
            `ST_CAP_DR: next_state = i_tms ? `ST_EX1_DR : `ST_SH_DR;
            `ST_SH_DR: next_state = i_tms ? `ST_EX1_DR : `ST_SH_DR;
            `ST_EX1_DR: next_state = i_tms ? `ST_UP_DR : `ST_PA_DR;
            `ST_PA_DR: next_state = i_tms ? `ST_EX2_DR : `ST_PA_DR;
            `ST_EX2_DR: next_state = i_tms ? `ST_UP_DR : `ST_SH_DR;
            `ST_UP_DR: next_state = i_tms ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_IR: next_state = i_tms ? `ST_RESET : `ST_CAP_IR;
            `ST_CAP_IR: next_state = i_tms ? `ST_EX1_IR : `ST_SH_IR;
            `ST_SH_IR: next_state = i_tms ? `ST_EX1_IR : `ST_SH_IR;
            `ST_EX1_IR: next_state = i_tms ? `ST_UP_IR : `ST_PA_IR;
            `ST_PA_IR: next_state = i_tms ? `ST_EX2_IR : `ST_PA_IR;
            `ST_EX2_IR: next_state = i_tms ? `ST_UP_IR : `ST_SH_IR;
            `ST_UP_IR: next_state = i_tms ? `ST_SEL_DR : `ST_IDLE;
            default: next_state = `ST_RESET;
        endcase
    end

    // Advances only on a detected rising test-clock edge
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_state <= `ST_RESET;
        end else if (i_sync_reset) begin
            o_state <= `ST_RESET;
        end else if (i_tck_rise) begin
            o_state <= next_state;
        end
    end
endmodule

// *** logic/scan_test_port.v ***
// Functional notes
// RL1: Standard test-port state sequencing, instruction handling and serial shifting.
// RL2: Scan works before and after configuration; controller avoids it during loads.
// RL3: Configuration data can be loaded through port configuration instructions.
// RL4: Sample instruction captures live pin values while core keeps running.
// RL5: Sample instruction preloads a pattern later driven by test instructions.
// RL6: External test drives output pins from the boundary register.
// RL7: External test captures input pin levels into the boundary register.
// RL8: Bypass gives a one-stage path from serial input to output.
// RL9: User-code instruction shifts out a 32-bit programmable identification word.
// RL10: Identification instruction shifts out the fixed identification word.
// RL11: Identification word is version, part number, maker, then constant bit.
// RL12: Identification word least significant bit always reads one.
// RL13: Analyzer instruction connects embedded logic analyzer chain to the port.
// RL14: Smallest-variant option keeps only bypass and analyzer instructions.
// RL15: Opcodes are parameters; all ones is bypass; reset selects identification. Opcodes here are fixed header macros, not parameters.
// RL16: Inputs sampled on rising test clock; output changes on falling edge.
`include "scan_port_defines.vh"

module scan_test_port #(
    parameter NUM_IN = 8,
    parameter NUM_OUT = 8,
    parameter LA_WIDTH = 16,
    parameter CFG_WIDTH = 8,
    parameter MIN_VARIANT = 0,
    parameter [3:0] ID_VERSION = `ID_VERSION,
    // Arbitrary identity values, not any real part
    parameter [15:0] ID_PART = `ID_PART,
    parameter [10:0] ID_MAKER = `ID_MAKER
) (
    input wire i_clk,
    input wire i_rstn,
    input wire i_tck,
    input wire i_tms,
    input wire i_tdi,
    input wire i_trstn,
    output reg o_tdo,
    output reg o_tdo_oen_n,
    input wire i_configuring,
    input wire [NUM_IN-1:0] i_pin_in,
    input wire [NUM_OUT-1:0] i_core_out,
    output reg [NUM_OUT-1:0] o_pin_out,
    input wire [LA_WIDTH-1:0] i_probe,
    input wire [31:0] i_usercode,
    output reg [CFG_WIDTH-1:0] o_cfg_data,
    output reg o_cfg_valid,
    output reg o_cfg_start,
    output reg o_scan_busy
);
    localparam BSR_LEN = NUM_IN + NUM_OUT;

    wire [3:0] sync_bus;
    wire tck_s;
    wire tms_s;
    wire tdi_s;
    wire trstn_s;
    reg tck_d;
    wire tck_rise;
    wire tck_fall;
    wire [3:0] state;

    reg [`IR_LEN-1:0] ir_shift;
    reg [`IR_LEN-1:0] ir;
    reg [BSR_LEN-1:0] bsr_shift;
    reg [BSR_LEN-1:0] bsr_hold;
    reg [31:0] id_shift;
    reg [LA_WIDTH-1:0] la_shift;
    reg [CFG_WIDTH-1:0] cfg_shift;
    reg bypass_reg;
    reg [NUM_IN-1:0] pin_in_s;
    reg [NUM_IN-1:0] pin_in_m;
    reg serial_bit;

    scan_pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_async({i_trstn, i_tdi, i_tms, i_tck}),
        .o_sync(sync_bus)
    );

    assign tck_s = sync_bus[0];
    assign tms_s = sync_bus[1];
    assign tdi_s = sync_bus[2];
    assign trstn_s = sync_bus[3];
    assign tck_rise = tck_s & ~tck_d; // RL16
    assign tck_fall = ~tck_s & tck_d; // RL16

    scan_tap_fsm u_fsm (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_tck_rise(tck_rise),
        .i_sync_reset(~trstn_s), // RL1
        .i_tms(tms_s),
        .o_state(state)
    );

    // Reduces the opcode to what this build really supports
    function [3:0] effective_op;
        input [3:0] op;
        begin
            if (MIN_VARIANT != 0 && op != `OP_BYPASS && op != `OP_ANALYZER)
                effective_op = `OP_BYPASS; // RL14
            else if (op == `OP_EXTEST || op == `OP_SAMPLE || op == `OP_IDCODE || op == `OP_USERCODE
                     || op == `OP_CFG_DATA || op == `OP_CFG_START || op == `OP_ANALYZER)
                effective_op = op;
            else
                effective_op = `OP_BYPASS; // RL15
        end
    endfunction

    // Boundary register is the data path for both pin instructions
    function is_bsr_op;
        input [3:0] code;
        begin
            is_bsr_op = (code == `OP_EXTEST) || (code == `OP_SAMPLE);
        end
    endfunction

    // Update-DR strobe for one given instruction
    function upd_for;
        input rise;
        input [3:0] cur_state;
        input [3:0] cur_op;
        input [3:0] want_op;
        begin
            upd_for = rise && (cur_state == `ST_UP_DR) && (cur_op == want_op);
        end
    endfunction

    wire [3:0] op = effective_op(ir);
    wire tlr = (state == `ST_RESET) || !trstn_s;
    wire bsr_sel = is_bsr_op(op);
    wire upd_cfg_data = upd_for(tck_rise, state, op, `OP_CFG_DATA);
    wire upd_cfg_start = upd_for(tck_rise, state, op, `OP_CFG_START);

    // Reset value matches the idle-low test clock, so no false edge follows reset
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tck_d <= 1'b0;
        end else begin
            tck_d <= tck_s;
        end
    end

    // Input pins are asynchronous; only the second stage is ever read
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_in_m <= {NUM_IN{1'b0}};
            pin_in_s <= {NUM_IN{1'b0}};
        end else begin
            pin_in_m <= i_pin_in;
            pin_in_s <= pin_in_m;
        end
    end

    // Instruction register
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ir_shift <= {`IR_LEN{1'b0}};
            ir <= `OP_IDCODE;
        end else if (tlr) begin
            ir <= `OP_IDCODE; // RL15
        end else if (tck_rise) begin
            case (state)
                `ST_CAP_IR: ir_shift <= `IR_CAPTURE; // RL1
                `ST_SH_IR: ir_shift <= {tdi_s, ir_shift[`IR_LEN-1:1]}; // RL1
                `ST_UP_IR: ir <= ir_shift; // RL1
                default: ir_shift <= ir_shift;
            endcase
        end
    end

    // Data registers; capture and shift on rising edges
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bsr_shift <= {BSR_LEN{1'b0}};
            bsr_hold <= {BSR_LEN{1'b0}};
            id_shift <= 32'h0;
            la_shift <= {LA_WIDTH{1'b0}};
            cfg_shift <= {CFG_WIDTH{1'b0}};
            bypass_reg <= 1'b0;
        end else if (tck_rise) begin
            case (state)
                `ST_CAP_DR: begin
                    bypass_reg <= 1'b0; // RL8
                    if (bsr_sel)
                        bsr_shift <= {pin_in_s, o_pin_out}; // RL4 RL7
                    if (op == `OP_IDCODE)
                        id_shift <= {ID_VERSION, ID_PART, ID_MAKER, 1'b1}; // RL10 RL11 RL12
                    else if (op == `OP_USERCODE)
                        id_shift <= i_usercode; // RL9
                    if (op == `OP_ANALYZER)
                        la_shift <= i_probe; // RL13
                end
                `ST_SH_DR: begin
                    case (op)
                        `OP_EXTEST, `OP_SAMPLE: bsr_shift <= {tdi_s, bsr_shift[BSR_LEN-1:1]};
                        `OP_IDCODE, `OP_USERCODE: id_shift <= {tdi_s, id_shift[31:1]};
                        `OP_ANALYZER: la_shift <= {tdi_s, la_shift[LA_WIDTH-1:1]};
                        `OP_CFG_DATA: cfg_shift <= {tdi_s, cfg_shift[CFG_WIDTH-1:1]}; // RL3
                        default: bypass_reg <= tdi_s; // RL8
                    endcase
                end
                `ST_UP_DR: begin
                    if (bsr_sel)
                        bsr_hold <= bsr_shift; // RL5
                end
                default: bypass_reg <= bypass_reg;
            endcase
        end
    end

    // Serial output source, chosen by instruction or state
    always @* begin
        if (state == `ST_SH_IR) begin
            serial_bit = ir_shift[0];
        end else begin
            case (op)
                `OP_EXTEST, `OP_SAMPLE: serial_bit = bsr_shift[0];
                `OP_IDCODE, `OP_USERCODE: serial_bit = id_shift[0];
                `OP_ANALYZER: serial_bit = la_shift[0];
                `OP_CFG_DATA: serial_bit = cfg_shift[0];
                default: serial_bit = bypass_reg;
            endcase
        end
    end

    // Output changes on falling edge so the controller samples it on the next rise
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_tdo <= 1'b0;
        end else if (tck_fall) begin
            o_tdo <= serial_bit; // RL16
        end
    end

    // Driver on only in the shift states; elsewhere the line rests at its pull-up
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_tdo_oen_n <= 1'b1;
        end else if (tck_fall) begin
            o_tdo_oen_n <= !(state == `ST_SH_DR || state == `ST_SH_IR); // RL1
        end
    end

    // Pin drive; a running configuration load wins over a test pattern
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pin_out <= {NUM_OUT{1'b0}};
        end else if (op == `OP_EXTEST && !i_configuring) begin
            o_pin_out <= bsr_hold[NUM_OUT-1:0]; // RL6
        end else begin
            o_pin_out <= i_core_out; // RL4 RL2
        end
    end

    // Configuration data and its one-cycle strobe leave together
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_cfg_data <= {CFG_WIDTH{1'b0}};
            o_cfg_valid <= 1'b0;
        end else begin
            o_cfg_valid <= upd_cfg_data; // RL3
            if (upd_cfg_data) begin
                o_cfg_data <= cfg_shift; // RL3
            end
        end
    end

    // Start strobe carries no data of its own
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_cfg_start <= 1'b0;
        end else begin
            o_cfg_start <= upd_cfg_start; // RL3
        end
    end

    // Tells the core its pins are borrowed by the test pattern
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_scan_busy <= 1'b0;
        end else begin
            o_scan_busy <= op == `OP_EXTEST; // RL2
        end
    end
endmodule

// *** verif/scan_test_port_properties.sv ***
module scan_test_port_properties #(
    parameter NUM_OUT = 8,
    parameter CFG_WIDTH = 8
) (
    input wire i_clk,
    input wire i_rstn,
    input wire i_tck,
    input wire [NUM_OUT-1:0] i_core_out,
    input wire o_tdo,
    input wire o_tdo_oen_n,
    input wire [NUM_OUT-1:0] o_pin_out,
    input wire [CFG_WIDTH-1:0] o_cfg_data,
    input wire o_cfg_valid,
    input wire o_cfg_start,
    input wire o_scan_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    property p_valid_pulse; o_cfg_valid |=> !o_cfg_valid; endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("config valid too long");
    property p_start_pulse; o_cfg_start |=> !o_cfg_start; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("config start too long");
    property p_data_hold; $changed(o_cfg_data) |-> o_cfg_valid; endproperty
    a_data_hold: assert property (p_data_hold) else $error("config data moved alone");
    property p_core_pass; !o_scan_busy ##1 !o_scan_busy |-> o_pin_out == $past(i_core_out); endproperty
    a_core_pass: assert property (p_core_pass) else $error("pins not from core");
    // Held pins may only move while the serial driver is off, never mid-shift
    property p_pin_quiet; o_scan_busy && $changed(o_pin_out) |-> o_tdo_oen_n; endproperty
    a_pin_quiet: assert property (p_pin_quiet) else $error("pins moved while shifting");
    property p_tdo_fall; $changed(o_tdo) |-> !$past(i_tck, 2); endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("serial out moved off fall");
    property p_oen_fall; $changed(o_tdo_oen_n) |-> !$past(i_tck, 2); endproperty
    a_oen_fall: assert property (p_oen_fall) else $error("enable moved off fall");
    property p_upd_idle; o_cfg_valid || o_cfg_start |-> o_tdo_oen_n; endproperty
    a_upd_idle: assert property (p_upd_idle) else $error("update during shift");
    property p_excl; o_cfg_valid |-> !o_scan_busy && !o_cfg_start; endproperty
    a_excl: assert property (p_excl) else $error("two instructions at once");
endmodule

bind scan_test_port scan_test_port_properties #(.NUM_OUT(NUM_OUT), .CFG_WIDTH(CFG_WIDTH)) chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_tck(i_tck), .i_core_out(i_core_out), .o_tdo(o_tdo),
    .o_tdo_oen_n(o_tdo_oen_n), .o_pin_out(o_pin_out), .o_cfg_data(o_cfg_data),
    .o_cfg_valid(o_cfg_valid), .o_cfg_start(o_cfg_start), .o_scan_busy(o_scan_busy));

// *** verif/scan_controller.sv ***
module scan_controller (
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire i_tdo
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end
    // Pins change only while the test clock is low, so the rise sees them settled
    task automatic step(input logic m, input logic d, output logic q);
        o_tck = 1'b0;
        o_tms = m;
        o_tdi = d;
        #80 o_tck = 1'b1;
        #80 q = i_tdo;
    endtask
    task automatic tlr();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
    task automatic shift(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        o_tck = 1'b0;
    endtask
endmodule

// *** verif/boundary_scan_test_port_bench.sv ***
`include "scan_port_defines.vh"
module boundary_scan_test_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] ID = {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1};
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [7:0] i_pin_in = 8'h00;
    logic [7:0] i_core_out = 8'h00;
    logic [15:0] i_probe = 16'h0000;
    logic [31:0] i_usercode = 32'h00000000;
    logic i_configuring = 1'b0;
    logic i_trstn = 1'b1;
    logic [31:0] r = 32'h00000B5C;
    logic [31:0] got;
    logic [31:0] dout;
    logic [31:0] q[$];
    int n_errors = 0;
    int cmp_count = 0;
    event got_ev;
    wire tck, tms, tdi, tdo, oen_n, cfg_valid, cfg_start, busy;
    wire [7:0] pin_out;
    wire [7:0] cfg_data;
    // Released serial line floats to its pull-up
    wire tdo_line = oen_n ? 1'b1 : tdo;
    always #10 i_clk = ~i_clk;
    scan_controller ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo_line));
    scan_test_port dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .i_trstn(i_trstn), .o_tdo(tdo), .o_tdo_oen_n(oen_n), .i_configuring(i_configuring), .i_pin_in(i_pin_in),
        .i_core_out(i_core_out), .o_pin_out(pin_out), .i_probe(i_probe), .i_usercode(i_usercode),
        .o_cfg_data(cfg_data), .o_cfg_valid(cfg_valid), .o_cfg_start(cfg_start), .o_scan_busy(busy));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Ends 7 ns past a falling system-clock edge so no link edge meets a system edge
    task automatic set_ins();
        repeat (32) r = lfsr(r);
        @(posedge i_clk);
        i_pin_in <= r[7:0];
        i_core_out <= r[15:8];
        i_probe <= r[23:8];
        i_usercode <= r;
        #17;
    endtask
    task automatic chk(input logic [31:0] v);
        logic [31:0] e;
        cmp_count++;
        e = (q.size() != 0) ? q.pop_front() : ~v;
        if (v !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, v, e);
        end
    endtask
    always @(got_ev) chk(got);
    always @(posedge i_clk) begin
        if (cfg_valid === 1'b1) chk({24'h000000, cfg_data});
        if (cfg_start === 1'b1) chk(32'h00000001);
    end
    task automatic xfer(input logic ir, input int n, input logic [31:0] din, input logic [31:0] e,
        input logic [31:0] m);
        q.push_back(e & m);
        ctl.shift(ir, n, din, dout);
        got = dout & m;
        -> got_ev;
        #20;
        $display("transfer done at %0t", $time);
    endtask
    task automatic look(input logic [31:0] v, input logic [31:0] e);
        q.push_back(e);
        got = v;
        -> got_ev;
        #20;
    endtask
    task automatic op(input logic [3:0] c);
        xfer(1'b1, 4, {28'h0000000, c}, {28'h0000000, `IR_CAPTURE}, 32'h0000000F);
    endtask
    task automatic print_verdict();
        if (q.size() != 0) n_errors++;
        $display("checks %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        n_errors++;
        print_verdict();
    end
    initial begin
        logic [31:0] pre;
        logic q1;
        repeat (5) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
        #17;
        ctl.tlr();
        xfer(1'b0, 32, 32'h0, ID, 32'hFFFFFFFF);
        set_ins();
        op(`OP_USERCODE);
        xfer(1'b0, 32, 32'h0, i_usercode, 32'hFFFFFFFF);
        op(`OP_BYPASS);
        xfer(1'b0, 9, r, {23'h0, r[7:0], 1'b0}, 32'h000001FF);
        op(4'h7);
        xfer(1'b0, 9, ~r, {23'h0, ~r[7:0], 1'b0}, 32'h000001FF);
        op(`OP_SAMPLE);
        pre = r;
        xfer(1'b0, 16, pre, {16'h0, i_pin_in, i_core_out}, 32'h0000FFFF);
        op(`OP_EXTEST);
        look({24'h0, pin_out}, {24'h0, pre[7:0]});
        look({31'h0, busy}, 32'h00000001);
        set_ins();
        xfer(1'b0, 16, r, {16'h0, i_pin_in, 8'h00}, 32'h0000FF00);
        look({24'h0, pin_out}, {24'h0, r[7:0]});
        @(posedge i_clk);
        i_configuring <= 1'b1;
        repeat (3) @(posedge i_clk);
        #17;
        look({24'h0, pin_out}, {24'h0, i_core_out});
        @(posedge i_clk);
        i_configuring <= 1'b0;
        #17;
        set_ins();
        op(`OP_ANALYZER);
        xfer(1'b0, 16, 32'h0, {16'h0, i_probe}, 32'h0000FFFF);
        op(`OP_CFG_DATA);
        q.push_back({24'h0, r[7:0]});
        ctl.shift(1'b0, 8, r, dout);
        op(`OP_CFG_START);
        q.push_back(32'h00000001);
        ctl.shift(1'b0, 1, 32'h0, dout);
        op(`OP_BYPASS);
        @(posedge i_clk);
        i_trstn <= 1'b0;
        repeat (4) @(posedge i_clk);
        i_trstn <= 1'b1;
        repeat (3) @(posedge i_clk);
        #17;
        ctl.step(1'b0, 1'b0, q1);
        xfer(1'b0, 32, 32'h0, ID, 32'hFFFFFFFF);
        ctl.tlr();
        xfer(1'b0, 32, 32'h0, ID, 32'hFFFFFFFF);
        print_verdict();
    end
endmodule
